// ---- sep_master.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Bus master model for the serial port
// ****************************************
module sep_master (
    // Link pins
    output logic serial_clk,
    output logic serial_in,
    output logic unit_pick_n,
    output logic pause_n,
    // Port answer
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    // Line floats while the port does not drive
    wire logic q_line = serial_out_oe ? serial_out : 1'bz;

    // Idle clock high; select low at power-up
    initial begin
        serial_clk = 1'b1;
        serial_in = 1'b0;
        unit_pick_n = 1'b0;
        pause_n = 1'b1;
    end

    // MSB first, 50 ns a bit
    task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx, output logic [3:0] k);
        rx = 8'hFF;
        k = 4'h0;
        for (int i = 7; i > 7 - n; i--) begin
            serial_in = tx[i];
            #5 serial_clk = 1'b0;
            #3 serial_clk = 1'b1;
            rx[i] = q_line;
            k = k + {3'h0, serial_out_oe};
            #42 serial_in = ~tx[i]; // Hold time over
        end
    endtask

    // Select with settle time
    task automatic sel();
        unit_pick_n = 1'b0;
        #20;
    endtask

    // Deselect and stay high long enough
    task automatic desel();
        unit_pick_n = 1'b1;
        #160;
    endtask

    // Clock held high before read data
    task automatic gap();
        #200;
    endtask

    // Pause only while selected, clock low
    task automatic hold_on(output logic oe);
        serial_clk = 1'b0;
        #10 pause_n = 1'b0;
        // Noise the paused port must ignore
        repeat (3) begin
            #20 serial_clk = 1'b1;
            serial_in = ~serial_in;
            #20 serial_clk = 1'b0;
        end
        #100 oe = serial_out_oe;
    endtask

    // Leave pause with clock low, then take held bit
    task automatic hold_off(output logic r);
        pause_n = 1'b1;
        #100 serial_clk = 1'b1;
        #100 r = q_line;
    endtask
endmodule
`default_nettype wire

// ---- sep_pkg.sv ----
`default_nettype none
// ****************************************
// Shared constants and types
// ****************************************
package sep_pkg;
    // Array organisation
    localparam int MEM_BYTES = 256;
    localparam int PAGE_BYTES = 16;
    localparam int ID_BYTES = 16;
    localparam logic [7:0] ERASED = 8'hFF;
    // Identification bytes, values arbitrary
    localparam logic [7:0] ID_MAKER = 8'h5A;
    localparam logic [7:0] ID_FAMILY = 8'hA5;
    localparam logic [7:0] ID_SIZE = 8'h3C;
    // Instruction codes and don't-care mask
    localparam logic [7:0] OP_MASK = 8'hF7;
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RDSR = 8'h05;
    localparam logic [7:0] OP_WRSR = 8'h01;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_RDID = 8'h83;
    localparam logic [7:0] OP_WRID = 8'h82;
    // Address bit selecting lock status or lock
    localparam int ID_LOCK_ABIT = 7;
    // Status fields
    localparam logic [3:0] SR_ONES = 4'hF;
    localparam logic [1:0] BP_RST = 2'h0;
    localparam logic [1:0] BP_ALL = 2'h3;
    localparam logic [1:0] BP_HALF = 2'h2;
    localparam logic [1:0] BP_QUARTER = 2'h1;
    localparam int BP_LSB = 2;
    // Synchroniser reset: {rx_tgl, lock_n, sclk, pause_n, pick_n}
    localparam logic [4:0] SYNC_RST = 5'h0A;
    // Link clock bound and settle gap for read data
    localparam int SCLK_MAX_MHZ = 20;
    localparam int CORE_MHZ = 50;
    localparam int READ_GAP_NS = 200;
    localparam int READ_GAP_CYC = (READ_GAP_NS * CORE_MHZ + 999) / 1000;
    localparam int FIFO_DEPTH = 2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_WDATA = 3'b010,
        ST_WSR = 3'b011,
        ST_LOAD = 3'b100,
        ST_RDATA = 3'b101,
        ST_SKIP = 3'b110
    } sep_state_t;

    typedef struct packed {
        logic [3:0] ones;
        logic [1:0] bp;
        logic wel;
        logic wip;
    } sep_status_t;
endpackage
`default_nettype wire

// ---- sep_port.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Serial EEPROM slave port
// ****************************************
module sep_port (
    // Core clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Serial link
    input wire logic serial_clk,
    input wire logic serial_in,
    input wire logic unit_pick_n,
    input wire logic pause_n,
    output logic serial_out,
    output logic serial_out_oe,
    // Protection pin
    input wire logic lock_pin_n
);

    // ****************************************
    // Declarations
    // ****************************************
    localparam int FIFO_D = sep_pkg::FIFO_DEPTH;
    logic [2:0] bit_cnt_q;
    logic tx_tgl_q;
    logic tx_s1_q;
    logic tx_s2_q;
    logic tx_d_q;
    logic tx_take;
    logic [6:0] shin_q;
    logic [7:0] rx_byte_q;
    logic rx_tgl_q;
    logic [7:0] sh_q;
    logic link_clr_q;
    logic [7:0] tx_word_q;
    logic [4:0] s1_q;
    logic [4:0] s2_q;
    logic pick_d_q;
    logic rx_d_q;
    logic pick_s;
    logic pause_s;
    logic sclk_s;
    logic lock_s;
    logic rx_s;
    logic sel_ok_q;
    logic hold_q;
    logic pend_q;
    logic [7:0] pend_byte_q;
    logic [7:0] fifo_q [FIFO_D];
    logic wp_q;
    logic rp_q;
    logic [1:0] cnt_q;
    logic fifo_in_rdy;
    logic fifo_out_vld;
    logic push;
    logic pop;
    logic drained;
    logic [7:0] b;
    sep_pkg::sep_state_t state_q;
    logic [7:0] cmd_q;
    logic [7:0] addr_q;
    logic rd_on_q;
    logic wel_q;
    logic [1:0] bp_q;
    logic id_lock_q;
    logic sr_we;
    logic mem_we;
    logic id_we;
    logic lid_we;
    logic wr_cmd;
    sep_pkg::sep_status_t status;
    logic [7:0] mem_q [sep_pkg::MEM_BYTES];
    logic [7:0] id_q [sep_pkg::ID_BYTES];

    // Masked opcode compare
    function automatic logic op_is(input logic [7:0] v, input logic [7:0] op);
        return (v & sep_pkg::OP_MASK) == op;
    endfunction

    // Block-protect test for an array address
    function automatic logic prot(input logic [7:0] a, input logic [1:0] bp);
        return (bp == sep_pkg::BP_ALL) || (bp == sep_pkg::BP_HALF && a[7])
            || (bp == sep_pkg::BP_QUARTER && (&a[7:6]));
    endfunction

    // ****************************************
    // Link domain
    // ****************************************
    // Input shifter; deselect clears it at once
    // restart on selection
    always_ff @(posedge serial_clk or posedge unit_pick_n) begin
        if (unit_pick_n) begin
            bit_cnt_q <= 3'h0;
            shin_q <= 7'h00;
        end else if (pause_n) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            shin_q <= {shin_q[5:0], serial_in};
        end
    end

    // Whole byte handed over: held word plus toggle
    always_ff @(posedge serial_clk or posedge link_clr_q) begin
        if (link_clr_q) begin
            rx_byte_q <= 8'h00;
            rx_tgl_q <= 1'b0;
        end else if (pause_n && bit_cnt_q == 3'h7) begin
            rx_byte_q <= {shin_q, serial_in};
            rx_tgl_q <= ~rx_tgl_q;
        end
    end

    // Output shifter on the falling edge
    // falling edge MSB first
    always_ff @(negedge serial_clk or posedge unit_pick_n) begin
        if (unit_pick_n) begin
            sh_q <= 8'h00;
            serial_out <= 1'b0;
        end else if (pause_n) begin
            if (bit_cnt_q == 3'h0) begin
                serial_out <= tx_word_q[7];
                sh_q <= {tx_word_q[6:0], 1'b0};
            end else begin
                serial_out <= sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
            end
        end
    end

    // Toggles as each byte start takes the read word
    // word taken at byte start
    always_ff @(negedge serial_clk or posedge link_clr_q) begin
        if (link_clr_q) begin
            tx_tgl_q <= 1'b0;
        end else if (!unit_pick_n && pause_n && bit_cnt_q == 3'h0) begin
            tx_tgl_q <= ~tx_tgl_q;
        end
    end

    // ****************************************
    // Core domain: pin synchronisers
    // ****************************************
    // Two flops per input, third stage for edges
    always_ff @(posedge core_clk) begin
        if (srst) begin
            s1_q <= sep_pkg::SYNC_RST;
            s2_q <= sep_pkg::SYNC_RST;
            pick_d_q <= 1'b0;
            rx_d_q <= 1'b0;
        end else begin
            s1_q <= {rx_tgl_q, lock_pin_n, serial_clk, pause_n, unit_pick_n};
            s2_q <= s1_q;
            pick_d_q <= s2_q[0];
            rx_d_q <= s2_q[4];
        end
    end

    assign pick_s = s2_q[0];
    assign pause_s = s2_q[1];
    assign sclk_s = s2_q[2];
    assign lock_s = s2_q[3];
    assign rx_s = s2_q[4];

    // Take toggle: two flops, third stage for edges
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_s1_q <= 1'b0;
            tx_s2_q <= 1'b0;
            tx_d_q <= 1'b0;
        end else begin
            tx_s1_q <= tx_tgl_q;
            tx_s2_q <= tx_s1_q;
            tx_d_q <= tx_s2_q;
        end
    end

    // Link has copied the word; next one may be fetched
    assign tx_take = tx_s2_q ^ tx_d_q;

    // Clears both link toggles and the held word while core is reset
    always_ff @(posedge core_clk) begin
        link_clr_q <= srst;
    end

    // Selection needs a falling edge first
    // falling edge arms
    always_ff @(posedge core_clk) begin
        if (srst || pick_s) begin
            sel_ok_q <= 1'b0;
        end else if (pick_d_q) begin
            sel_ok_q <= 1'b1;
        end
    end

    // Pause state, moves only while clock is low; deselect clears it at any clock level
    // enter and leave
    always_ff @(posedge core_clk) begin
        if (srst || pick_s) begin
            hold_q <= 1'b0;
        end else if (!sclk_s) begin
            hold_q <= !pause_s && sel_ok_q;
        end
    end

    // ****************************************
    // Byte capture and two-entry buffer
    // ****************************************
    // Pending byte waits until the buffer has room
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pend_q <= 1'b0;
            pend_byte_q <= 8'h00;
        end else if ((rx_s ^ rx_d_q) && sel_ok_q) begin
            pend_q <= 1'b1;
            pend_byte_q <= rx_byte_q;
        end else if (fifo_in_rdy) begin
            pend_q <= 1'b0;
        end
    end

    assign fifo_in_rdy = cnt_q != 2'(FIFO_D);
    assign fifo_out_vld = cnt_q != 2'h0;
    assign push = pend_q && fifo_in_rdy;
    assign pop = fifo_out_vld && state_q != sep_pkg::ST_LOAD;
    assign b = fifo_q[rp_q];
    assign drained = pick_s && !fifo_out_vld && !pend_q;

    // Buffer pointers and storage
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end else begin
            if (push) begin
                fifo_q[wp_q] <= pend_byte_q;
                wp_q <= ~wp_q;
            end
            if (pop) begin
                rp_q <= ~rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    // Steps through instruction, address and data bytes
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q <= sep_pkg::ST_IDLE;
            cmd_q <= 8'h00;
            addr_q <= 8'h00;
            rd_on_q <= 1'b0;
        end else if (drained) begin
            state_q <= sep_pkg::ST_IDLE;
            rd_on_q <= 1'b0;
        end else if (pop || state_q == sep_pkg::ST_LOAD || (state_q == sep_pkg::ST_RDATA && tx_take)) begin
            unique case (state_q)
                sep_pkg::ST_IDLE: begin
                    cmd_q <= b;
                    if (op_is(b, sep_pkg::OP_RDSR)) begin
                        state_q <= sep_pkg::ST_LOAD;
                    end else if (op_is(b, sep_pkg::OP_WRSR)) begin
                        state_q <= sep_pkg::ST_WSR;
                    end else if (op_is(b, sep_pkg::OP_READ) || op_is(b, sep_pkg::OP_WRITE)
                        || op_is(b, sep_pkg::OP_RDID) || op_is(b, sep_pkg::OP_WRID)) begin
                        state_q <= sep_pkg::ST_ADDR;
                    end else begin
                        state_q <= sep_pkg::ST_SKIP;
                    end
                end
                sep_pkg::ST_ADDR: begin
                    addr_q <= b;
                    if (op_is(cmd_q, sep_pkg::OP_READ) || op_is(cmd_q, sep_pkg::OP_RDID)) begin
                        state_q <= sep_pkg::ST_LOAD;
                    end else begin
                        state_q <= sep_pkg::ST_WDATA;
                    end
                end
                sep_pkg::ST_WDATA: begin
                    addr_q[3:0] <= addr_q[3:0] + 4'h1;
                end
                sep_pkg::ST_WSR: begin
                    state_q <= sep_pkg::ST_SKIP;
                end
                sep_pkg::ST_LOAD: begin
                    rd_on_q <= 1'b1;
                    state_q <= sep_pkg::ST_RDATA;
                    if (op_is(cmd_q, sep_pkg::OP_READ)) begin
                        addr_q <= addr_q + 8'h01;
                    end else if (op_is(cmd_q, sep_pkg::OP_RDID)) begin
                        addr_q[3:0] <= addr_q[3:0] + 4'h1;
                    end
                end
                // prefetch once the word is taken
                sep_pkg::ST_RDATA: begin
                    if (tx_take) begin
                        state_q <= sep_pkg::ST_LOAD;
                    end
                end
                sep_pkg::ST_SKIP: begin
                    state_q <= sep_pkg::ST_SKIP;
                end
                default: begin
                    state_q <= sep_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Status, protection and storage
    // ****************************************
    assign wr_cmd = op_is(cmd_q, sep_pkg::OP_WRITE) || op_is(cmd_q, sep_pkg::OP_WRSR)
        || op_is(cmd_q, sep_pkg::OP_WRID);
    assign sr_we = pop && state_q == sep_pkg::ST_WSR && wel_q && lock_s;
    assign mem_we = pop && state_q == sep_pkg::ST_WDATA && wel_q
        && op_is(cmd_q, sep_pkg::OP_WRITE) && !prot(addr_q, bp_q);
    assign id_we = pop && state_q == sep_pkg::ST_WDATA && wel_q && op_is(cmd_q, sep_pkg::OP_WRID)
        && !addr_q[sep_pkg::ID_LOCK_ABIT] && !id_lock_q && bp_q != sep_pkg::BP_ALL;
    assign lid_we = pop && state_q == sep_pkg::ST_WDATA && wel_q && op_is(cmd_q, sep_pkg::OP_WRID)
        && addr_q[sep_pkg::ID_LOCK_ABIT];
    assign status = '{ones: sep_pkg::SR_ONES, bp: bp_q, wel: wel_q, wip: 1'b0};

    // Write latch, block protect and page lock
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wel_q <= 1'b0;
            bp_q <= sep_pkg::BP_RST;
            id_lock_q <= 1'b0;
        end else begin
            if (pop && state_q == sep_pkg::ST_IDLE && op_is(b, sep_pkg::OP_WREN)) begin
                wel_q <= 1'b1;
            end
            if (pop && state_q == sep_pkg::ST_IDLE && op_is(b, sep_pkg::OP_WRDI)) begin
                wel_q <= 1'b0;
            end
            if (drained && state_q != sep_pkg::ST_IDLE && wr_cmd) begin
                wel_q <= 1'b0;
            end
            if (sr_we) begin
                bp_q <= b[sep_pkg::BP_LSB+1:sep_pkg::BP_LSB];
            end
            if (lid_we) begin
                id_lock_q <= 1'b1;
            end
        end
    end

    // Array and identification page, byte writes
    // byte alterable array
    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < sep_pkg::MEM_BYTES; i++) begin
                mem_q[i] <= sep_pkg::ERASED;
            end
            for (int i = 0; i < sep_pkg::ID_BYTES; i++) begin
                id_q[i] <= sep_pkg::ERASED;
            end
            id_q[0] <= sep_pkg::ID_MAKER;
            id_q[1] <= sep_pkg::ID_FAMILY;
            id_q[2] <= sep_pkg::ID_SIZE;
        end else begin
            if (mem_we) begin
                mem_q[addr_q] <= b;
            end
            if (id_we) begin
                id_q[addr_q[3:0]] <= b;
            end
        end
    end

    // Next read byte; held stable across the link
    // clock bound lets word settle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_word_q <= 8'h00;
        end else if (state_q == sep_pkg::ST_LOAD) begin
            if (op_is(cmd_q, sep_pkg::OP_RDSR)) begin
                tx_word_q <= status;
            end else if (op_is(cmd_q, sep_pkg::OP_READ)) begin
                tx_word_q <= mem_q[addr_q];
            end else if (addr_q[sep_pkg::ID_LOCK_ABIT]) begin
                tx_word_q <= {7'h00, id_lock_q};
            end else begin
                tx_word_q <= id_q[addr_q[3:0]];
            end
        end
    end

    // Drive enable for the data-out pin
    // drive only for reads
    always_ff @(posedge core_clk) begin
        if (srst) begin
            serial_out_oe <= 1'b0;
        end else begin
            serial_out_oe <= rd_on_q && sel_ok_q && !pick_s && !hold_q;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    sequence s_pause_req;
        !pause_s && !sclk_s && sel_ok_q && !pick_s;
    endsequence
    sequence s_resume_req;
        pause_s && !sclk_s && !pick_s;
    endsequence

    a_pause_enter: assert property (s_pause_req |=> hold_q ##1 !serial_out_oe)
        else $error("pause not entered");
    a_pause_leave: assert property (s_resume_req |=> !hold_q)
        else $error("pause not left");
    a_desel_float: assert property (pick_s |=> !serial_out_oe && !hold_q)
        else $error("drive while deselected");
    a_pause_float: assert property (hold_q |=> !serial_out_oe)
        else $error("drive while paused");
    a_idle_float: assert property (!rd_on_q |=> !serial_out_oe)
        else $error("drive without read");
    a_fall_arms: assert property ($rose(sel_ok_q) |-> $past(pick_s, 2) && !$past(pick_s))
        else $error("selected without falling edge");
    a_lock_keeps_sr: assert property (!lock_s |=> $stable(bp_q))
        else $error("status changed while locked");
    a_id_lock_holds: assert property (id_lock_q |-> !id_we)
        else $error("write to locked page");
    a_array_write_ok: assert property (mem_we |-> wel_q && state_q == sep_pkg::ST_WDATA)
        else $error("array write without enable");
    a_frame_restart: assert property (drained |=> state_q == sep_pkg::ST_IDLE && !rd_on_q)
        else $error("sequence kept after deselect");
    a_stall_keeps: assert property (pend_q && !fifo_in_rdy |=> pend_q)
        else $error("pending byte lost");
    a_read_refill: assert property (state_q == sep_pkg::ST_RDATA && tx_take && !drained |=> state_q == sep_pkg::ST_LOAD)
        else $error("next read word not fetched");

endmodule
`default_nettype wire

// ---- sep_port_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(w, e, s) begin n_compared++; if ((s) !== (e)) begin n_fail++; $display("FAIL %s exp %h seen %h", w, e, s); end end
module sep_port_tb;
    // Clock, reset and pins
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic lock_pin_n = 1'b1;
    wire logic serial_clk, serial_in, unit_pick_n, pause_n, serial_out, serial_out_oe;
    int n_fail = 0;
    int n_compared = 0;
    logic [7:0] g[$];

    // Core clock, 20 ns
    always #10 core_clk = ~core_clk;

    sep_port dut_u (.core_clk(core_clk), .srst(srst), .serial_clk(serial_clk), .serial_in(serial_in),
        .unit_pick_n(unit_pick_n), .pause_n(pause_n), .serial_out(serial_out),
        .serial_out_oe(serial_out_oe), .lock_pin_n(lock_pin_n));
    sep_master mst_u (.serial_clk(serial_clk), .serial_in(serial_in), .unit_pick_n(unit_pick_n),
        .pause_n(pause_n), .serial_out(serial_out), .serial_out_oe(serial_out_oe));

    // Expected status byte
    function automatic logic [7:0] st(input logic [1:0] bp, input logic wel);
        return {sep_pkg::SR_ONES, bp, wel, 1'b0};
    endfunction

    // Command bytes, port must stay quiet
    task automatic send(input logic [7:0] q[$]);
        logic [7:0] r;
        logic [3:0] k;
        foreach (q[i]) begin
            mst_u.xfer(q[i], 8, r, k);
            `CHK("oe in command", 4'h0, k)
        end
    endtask

    // Write frame
    task automatic wr(input logic [7:0] q[$]);
        mst_u.sel();
        send(q);
        mst_u.desel();
        `CHK("oe after deselect", 1'b0, serial_out_oe)
    endtask

    // Read frame of n bytes into g
    task automatic rd(input logic [7:0] q[$], input int n);
        logic [7:0] r;
        logic [3:0] k;
        g = {};
        mst_u.sel();
        send(q);
        mst_u.gap();
        repeat (n) begin
            mst_u.xfer(8'hFF, 8, r, k);
            `CHK("oe in read", 4'h8, k)
            g.push_back(r);
        end
        mst_u.desel();
        `CHK("oe after read", 1'b0, serial_out_oe)
    endtask

    // Traffic before first select edge
    task automatic t_unsel();
        logic [7:0] r;
        logic [3:0] k;
        mst_u.xfer(sep_pkg::OP_WREN, 8, r, k);
        mst_u.xfer(sep_pkg::OP_RDSR, 8, r, k);
        mst_u.gap();
        mst_u.xfer(8'hFF, 8, r, k);
        `CHK("oe unselected", 4'h0, k)
        mst_u.desel();
        rd('{sep_pkg::OP_RDSR}, 1);
        `CHK("status unselected", st(sep_pkg::BP_RST, 1'b0), g[0])
        $display("test unsel done");
    endtask

    // Page wrap and array wrap
    task automatic t_page();
        wr('{sep_pkg::OP_WREN});
        rd('{sep_pkg::OP_RDSR}, 1);
        `CHK("wel set", st(sep_pkg::BP_RST, 1'b1), g[0])
        wr('{sep_pkg::OP_WRDI});
        rd('{sep_pkg::OP_RDSR}, 1);
        `CHK("wel cleared", st(sep_pkg::BP_RST, 1'b0), g[0])
        wr('{sep_pkg::OP_WREN});
        wr('{sep_pkg::OP_WRITE, 8'h0E, 8'hA1, 8'hB2, 8'hC3});
        rd('{sep_pkg::OP_READ, 8'h0D}, 3);
        `CHK("byte 0D", 8'hFF, g[0])
        `CHK("byte 0E", 8'hA1, g[1])
        `CHK("byte 0F", 8'hB2, g[2])
        rd('{sep_pkg::OP_READ, 8'hFF}, 2);
        `CHK("byte FF", 8'hFF, g[0])
        `CHK("byte 00", 8'hC3, g[1])
        $display("test page done");
    endtask

    // Status guard by protect pin
    task automatic t_lock();
        @(negedge core_clk) lock_pin_n = 1'b0;
        wr('{sep_pkg::OP_WREN});
        wr('{sep_pkg::OP_WRSR, 8'h0C});
        rd('{sep_pkg::OP_RDSR}, 1);
        `CHK("bp frozen", sep_pkg::BP_RST, g[0][3:2])
        @(negedge core_clk) lock_pin_n = 1'b1;
        wr('{sep_pkg::OP_WREN});
        wr('{sep_pkg::OP_WRSR, 8'h04});
        rd('{sep_pkg::OP_RDSR}, 1);
        `CHK("bp quarter", st(sep_pkg::BP_QUARTER, 1'b0), g[0])
        wr('{sep_pkg::OP_WREN});
        wr('{sep_pkg::OP_WRITE, 8'hC0, 8'h55});
        rd('{sep_pkg::OP_READ, 8'hC0}, 1);
        `CHK("protected C0", 8'hFF, g[0])
        wr('{sep_pkg::OP_WREN});
        wr('{sep_pkg::OP_WRSR, 8'h00});
        $display("test lock done");
    endtask

    // Identification page and its lock
    task automatic t_idpage();
        rd('{sep_pkg::OP_RDID, 8'h00}, 3);
        `CHK("id 0", sep_pkg::ID_MAKER, g[0])
        `CHK("id 2", sep_pkg::ID_SIZE, g[2])
        wr('{sep_pkg::OP_WREN});
        wr('{sep_pkg::OP_WRID, 8'h05, 8'h77});
        rd('{sep_pkg::OP_RDID, 8'h80}, 1);
        `CHK("unlocked", 8'h00, g[0])
        wr('{sep_pkg::OP_WREN});
        wr('{sep_pkg::OP_WRID, 8'h80, 8'h00});
        wr('{sep_pkg::OP_WREN});
        wr('{sep_pkg::OP_WRID, 8'h05, 8'h88});
        rd('{sep_pkg::OP_RDID, 8'h80}, 1);
        `CHK("locked", 8'h01, g[0])
        rd('{sep_pkg::OP_RDID, 8'h05}, 1);
        `CHK("id 5 kept", 8'h77, g[0])
        $display("test idpage done");
    endtask

    // Pause in mid read byte
    task automatic t_pause();
        logic [7:0] r;
        logic [7:0] t;
        logic [3:0] k;
        logic b;
        mst_u.sel();
        send('{sep_pkg::OP_READ, 8'h0E});
        mst_u.gap();
        mst_u.xfer(8'hFF, 4, r, k);
        mst_u.hold_on(b);
        `CHK("oe paused", 1'b0, b)
        mst_u.hold_off(b);
        mst_u.xfer(8'hFF, 3, t, k);
        r[3] = b;
        r[2:0] = t[7:5];
        `CHK("byte across pause", 8'hA1, r)
        mst_u.desel();
        $display("test pause done");
    endtask

    // Partial frame and deselect while paused
    task automatic t_abandon();
        logic [7:0] r;
        logic [3:0] k;
        logic b;
        mst_u.sel();
        mst_u.xfer(8'hA0, 3, r, k);
        mst_u.desel();
        rd('{sep_pkg::OP_RDSR}, 1);
        `CHK("status after stub", st(sep_pkg::BP_RST, 1'b0), g[0])
        wr('{sep_pkg::OP_WREN});
        mst_u.sel();
        send('{sep_pkg::OP_WRITE, 8'h30});
        mst_u.xfer(8'h99, 4, r, k);
        mst_u.hold_on(b);
        mst_u.desel();
        mst_u.hold_off(b);
        rd('{sep_pkg::OP_READ, 8'h30}, 1);
        `CHK("abandoned write", 8'hFF, g[0])
        $display("test abandon done");
    endtask

    // Verdict and end of run
    task automatic complete_run();
        $display("Compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(negedge core_clk);
        srst = 1'b0;
        repeat (3) @(negedge core_clk);
        t_unsel();
        t_page();
        t_lock();
        t_idpage();
        t_pause();
        t_abandon();
        complete_run();
    end

    // Watchdog
    initial begin
        #500000;
        n_fail++;
        complete_run();
    end
endmodule
`default_nettype wire
